//--- verilog/rcs_ctrl.sv
`timescale 1ns/100ps
module rcs_ctrl #(
  parameter int PRESC_W = rcs_pkg::PRESC_STAGES, // Normal divider length
  parameter int TEST_W = rcs_pkg::TEST_STAGES // Test divider length
) (
  input wire logic clk_i, // System clock, 100 MHz
  input wire logic arst_n_i, // Power-on reset, active low
  input wire logic osc_tick_i, // 32.768 kHz oscillator enable pulse
  input wire logic wr_en_i, // Register write strobe from serial port
  input wire logic [7:0] wr_addr_i, // Register address of the write
  input wire logic [7:0] wr_data_i, // Written byte
  input wire logic rd_en_i, // Register read strobe
  input wire logic [7:0] rd_addr_i, // Register address of the read
  output logic [7:0] rd_data_o, // Read byte, registered
  input wire logic corr_cycle_i, // Frequency correction cycle pulse
  output logic corr_irq_o, // Correction interrupt pulse
  output logic hour_12_o, // 1 selects 12-hour counting
  output logic load_cap_o, // 1 selects 12.5 pF load
  output logic halted_o, // Time counters frozen, writes accepted
  output logic sec_tick_o, // One-second increment pulse
  output logic soft_reset_o, // Reset all registers and address pointer
  input wire logic clock_output_pin_i, // Clock pin level in test mode
  output logic clock_output_pin_o, // Clock pin drive level
  output logic clock_output_pin_oe_o, // Clock pin drive enable
  input wire logic [2:0] clock_output_pin_sel_i, // Clock out tap: 0..5 divided, 6 = 1 Hz, 7 off
  output logic test_clk_err_o // Test clock pulse or period out of range
);
  import rcs_pkg::*;

  logic [7:0] ctrl_q;
  logic [7:0] ctrl_d;
  logic soft_rst_q;
  logic test_clk_q;
  logic [PRESC_W-1:0] stage_q;
  logic [PRESC_W:0] carry;
  logic [PRESC_W-1:0] clear;
  logic ext_clock_test_select;
  logic halt;
  logic ctrl_wr;
  logic soft_cmd;
  logic test_edge;
  logic step;
  logic top_rise;
  logic top_q;
  logic tick_q;
  logic irq_q;
  logic clk_out_q;
  logic [7:0] hi_cnt_q;
  logic [7:0] per_cnt_q;
  logic err_q;
  logic [8:0] hold_cnt_q;
  logic restart_hold;

  // Write decode; any control register write with the reset bit set acts as the reset command
  assign ctrl_wr = wr_en_i && (wr_addr_i == CTRL_ONE_ADDR);
  assign soft_cmd = ctrl_wr && wr_data_i[SOFT_RESET_BIT];
  assign ctrl_d = soft_cmd ? CTRL_ONE_RESET : (wr_data_i & CTRL_ONE_MASK);

  // Control register
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      ctrl_q <= CTRL_ONE_RESET;
    end else if (ctrl_wr) begin
      ctrl_q <= ctrl_d;
    end
  end

  // Soft reset pulse, one cycle after the command
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      soft_rst_q <= 1'b0;
    end else begin
      soft_rst_q <= soft_cmd;
    end
  end
  assign soft_reset_o = soft_rst_q;

  assign ext_clock_test_select = ctrl_q[EXT_CLOCK_TEST_SELECT_BIT];
  assign halt = ctrl_q[HALT_BIT];
  assign hour_12_o = ctrl_q[HOUR_MODE_BIT];
  assign load_cap_o = ctrl_q[LOAD_CAP_BIT];
  assign halted_o = halt;

  // Restart hold: a plain release would tick after half a second, which is
  // too early; holding the upper stages a little longer lands the first tick in
  // the allowed window, with one 8 kHz cycle of uncertainty from the low stages.
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      hold_cnt_q <= 9'h000;
    end else if (halt) begin
      hold_cnt_q <= 9'(RESTART_HOLD_TICKS);
    end else if (osc_tick_i && (hold_cnt_q != 9'h000)) begin
      hold_cnt_q <= hold_cnt_q - 9'h001;
    end
  end
  // Test mode must tick after exactly 32 edges, so the hold never applies there
  assign restart_hold = (hold_cnt_q != 9'h000) & ~ext_clock_test_select;

  // Read path; soft reset bit and unused bits always zero
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      rd_data_o <= 8'h00;
    end else if (rd_en_i) begin
      rd_data_o <= (rd_addr_i == CTRL_ONE_ADDR) ? (ctrl_q & CTRL_ONE_MASK) : 8'h00;
    end
  end

  // Test clock pin sample, for edge detection
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      test_clk_q <= 1'b0;
    end else begin
      test_clk_q <= clock_output_pin_i;
    end
  end
  assign test_edge = clock_output_pin_i & ~test_clk_q;
  assign step = ext_clock_test_select ? test_edge : osc_tick_i;

  // Test mode feeds stage PRESC_W-TEST_W, so six stages reach 1 Hz.
  // Stages are not cleared on test entry; the halt bit does that.
  assign carry[0] = step & ~ext_clock_test_select;

  genvar g;
  generate
    for (g = 0; g < PRESC_W; g++) begin : g_stage
      logic cin;
      if (g == PRESC_W - TEST_W) begin : g_inj
        assign cin = carry[g] | (step & ext_clock_test_select);
      end else begin : g_pass
        assign cin = carry[g];
      end
      if (g < LOW_STAGES) begin : g_low
        assign clear[g] = 1'b0;
      end else begin : g_high
        assign clear[g] = halt | restart_hold;
      end
      rcs_presc_stage u_stage (
        .clk_i(clk_i),
        .arst_n_i(arst_n_i),
        .clear_i(clear[g]),
        .carry_i(cin),
        .q_o(stage_q[g]),
        .carry_o(carry[g+1])
      );
    end
  endgenerate

  // Seconds tick on the 0 to 1 transition of the top stage
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      top_q <= 1'b0;
    end else begin
      top_q <= stage_q[PRESC_W-1];
    end
  end
  assign top_rise = stage_q[PRESC_W-1] & ~top_q;

  // Registered tick; suppressed outright while halted
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      tick_q <= 1'b0;
    end else begin
      tick_q <= top_rise & ~halt;
    end
  end
  assign sec_tick_o = tick_q;

  // Correction interrupt pulse
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      irq_q <= 1'b0;
    end else begin
      irq_q <= corr_cycle_i & ctrl_q[CORR_IRQ_BIT];
    end
  end
  assign corr_irq_o = irq_q;

  // Clock output tap; taps slower than 8 kHz are cleared by halt and, like
  // the 1 Hz tap, are forced low while halted so no stale level leaks out.
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      clk_out_q <= 1'b0;
    end else if (clock_output_pin_sel_i == 3'h7) begin
      clk_out_q <= 1'b0;
    end else if (clock_output_pin_sel_i == 3'h6) begin
      clk_out_q <= stage_q[PRESC_W-1] & ~halt;
    end else if (clock_output_pin_sel_i > 3'(FAST_TAP_STAGES)) begin
      clk_out_q <= stage_q[clock_output_pin_sel_i - 3'h1] & ~halt;
    end else if (clock_output_pin_sel_i == 3'h0) begin
      clk_out_q <= stage_q[0];
    end else begin
      clk_out_q <= stage_q[clock_output_pin_sel_i - 3'h1];
    end
  end
  assign clock_output_pin_oe_o = ~ext_clock_test_select;
  assign clock_output_pin_o = clk_out_q;

  // Test clock monitor: high pulse and low pulse widths, and period
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      hi_cnt_q <= 8'h00;
      per_cnt_q <= 8'h00;
      err_q <= 1'b0;
    end else if (!ext_clock_test_select || soft_cmd) begin
      hi_cnt_q <= 8'h00;
      per_cnt_q <= 8'h00;
      err_q <= 1'b0;
    end else begin
      hi_cnt_q <= (clock_output_pin_i != test_clk_q) ? 8'h01 : hi_cnt_q + 8'h01;
      per_cnt_q <= test_edge ? 8'h01 : per_cnt_q + 8'h01;
      if ((clock_output_pin_i != test_clk_q && per_cnt_q != 8'h00 &&
           hi_cnt_q < 8'(TEST_MIN_PULSE_CYC)) ||
          per_cnt_q > 8'(TEST_MAX_PERIOD_CYC)) begin
        err_q <= 1'b1;
      end
    end
  end
  assign test_clk_err_o = err_q;
endmodule // rcs_ctrl

//--- verilog/rcs_pkg.sv
package rcs_pkg;
  // Register map: only the first control register lives here
  localparam logic [7:0] CTRL_ONE_ADDR = 8'h00;
  localparam logic [7:0] CTRL_ONE_RESET = 8'h00;
  localparam logic [7:0] SOFT_RESET_CMD = 8'h58;
  // Field positions
  localparam int EXT_CLOCK_TEST_SELECT_BIT = 7;
  localparam int HALT_BIT = 5;
  localparam int SOFT_RESET_BIT = 4;
  localparam int CORR_IRQ_BIT = 2;
  localparam int HOUR_MODE_BIT = 1;
  localparam int LOAD_CAP_BIT = 0;
  // Bits that store a value; unused bits and the reset trigger read zero
  localparam logic [7:0] CTRL_ONE_MASK = 8'h87 | 8'h20;
  // Prescaler: 15 stages from oscillator to 1 Hz, 6 stages in test mode
  localparam int PRESC_STAGES = 15;
  localparam int TEST_STAGES = 6;
  localparam int LOW_STAGES = 2;
  // Oscillator ticks that the upper stages stay cleared after a normal-mode release
  localparam int RESTART_HOLD_TICKS = 260;
  // Tap whose output is 8.192 kHz; lower taps are 8 kHz or faster
  localparam int FAST_TAP_STAGES = 2;
  // Test clock limits, in ns, against the 10 ns system clock
  localparam int CLK_PERIOD_NS = 10;
  localparam int TEST_MIN_PULSE_NS = 300;
  localparam int TEST_MAX_PERIOD_NS = 1000;
  localparam int TEST_MIN_PULSE_CYC = (TEST_MIN_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int TEST_MAX_PERIOD_CYC = TEST_MAX_PERIOD_NS / CLK_PERIOD_NS;
endpackage

//--- verilog/rcs_presc_stage.sv
`timescale 1ns/100ps
// One toggle stage of the divider chain; clear forces it to zero
module rcs_presc_stage (
  input wire logic clk_i, // System clock
  input wire logic arst_n_i, // Asynchronous reset
  input wire logic clear_i, // Hold stage at zero
  input wire logic carry_i, // Carry from lower stages
  output logic q_o, // Stage output
  output logic carry_o // Carry to next stage
);
  logic q_q;
  logic q_d;

  // Toggle on carry unless held in clear
  assign q_d = clear_i ? 1'b0 : (q_q ^ carry_i);
  assign q_o = q_q;
  assign carry_o = carry_i & q_q;

  // Stage flip-flop
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      q_q <= 1'b0;
    end else begin
      q_q <= q_d;
    end
  end
endmodule // rcs_presc_stage

//--- test/rcs_ctrl_assertions.sv
`timescale 1ns/100ps
// Port-level checks of the first control register and the halt gating
module rcs_ctrl_assertions (
  input wire logic clk_i, // Clock
  input wire logic arst_n_i, // Reset, active low
  input wire logic wr_en_i, // Write strobe
  input wire logic [7:0] wr_addr_i, // Write address
  input wire logic [7:0] wr_data_i, // Write byte
  input wire logic rd_en_i, // Read strobe
  input wire logic [7:0] rd_data_o, // Read byte
  input wire logic corr_cycle_i, // Correction cycle
  input wire logic corr_irq_o, // Correction pulse
  input wire logic hour_12_o, // Hour format
  input wire logic load_cap_o, // Load select
  input wire logic halted_o, // Halt level
  input wire logic sec_tick_o, // Seconds pulse
  input wire logic soft_reset_o, // Soft reset pulse
  input wire logic clock_output_pin_o, // Pin level
  input wire logic clock_output_pin_oe_o, // Pin enable
  input wire logic [2:0] clock_output_pin_sel_i // Tap select
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!arst_n_i);
  // Plain stores exclude the reset trigger, which clears everything instead
  wire logic wr0 = wr_en_i && wr_addr_i == 8'h00;
  wire logic st0 = wr0 && !wr_data_i[4];
  a_irq_follows: assert property (corr_irq_o |-> $past(corr_cycle_i))
    else $error("correction pulse without cycle");
  a_test_pin_in: assert property (st0 |=> clock_output_pin_oe_o == !$past(wr_data_i[7]))
    else $error("pin enable not following test bit");
  a_halt_set: assert property (st0 |=> halted_o == $past(wr_data_i[5]))
    else $error("halt not following bit");
  a_fields_load: assert property (st0 |=> hour_12_o == $past(wr_data_i[1])
    && load_cap_o == $past(wr_data_i[0])) else $error("format or load bit wrong");
  a_sr_clears: assert property (wr0 && wr_data_i[4] |=> soft_reset_o
    && !halted_o && !hour_12_o && clock_output_pin_oe_o) else $error("soft reset wrong");
  a_no_tick: assert property (halted_o && $past(halted_o, 3) |-> !sec_tick_o)
    else $error("tick while halted");
  a_read_mask: assert property (rd_en_i |=> (rd_data_o & 8'h58) == 8'h00)
    else $error("unstored bit reads one");
  a_clock_output_pin_low: assert property (halted_o && $past(halted_o, 2) && clock_output_pin_sel_i == 3'h6
    && $past(clock_output_pin_sel_i) == 3'h6 && clock_output_pin_oe_o |-> !clock_output_pin_o)
    else $error("slow clock out while halted");
endmodule // rcs_ctrl_assertions
bind rcs_ctrl rcs_ctrl_assertions u_chk (.clk_i, .arst_n_i, .wr_en_i, .wr_addr_i, .wr_data_i,
  .rd_en_i, .rd_data_o, .corr_cycle_i, .corr_irq_o, .hour_12_o, .load_cap_o, .halted_o,
  .sec_tick_o, .soft_reset_o, .clock_output_pin_o, .clock_output_pin_oe_o, .clock_output_pin_sel_i);

//--- test/rcs_host.sv
`timescale 1ns/100ps
// Register host: single-byte strobed writes and reads on the falling edge
module rcs_host import rcs_pkg::*; (
  input wire logic clk_i, // Clock
  input wire logic [7:0] rd_data_i, // Read byte
  output logic wr_en_o, // Write strobe
  output logic [7:0] wr_addr_o, // Write address
  output logic [7:0] wr_data_o, // Write byte
  output logic rd_en_o, // Read strobe
  output logic [7:0] rd_addr_o // Read address
);
  // Idle lines carry the inverse of the last value so stale data never matches
  initial begin
    wr_en_o = 1'b0;
    rd_en_o = 1'b0;
    wr_addr_o = 8'hff;
    wr_data_o = 8'hff;
    rd_addr_o = 8'hff;
  end
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk_i);
    wr_en_o = 1'b1;
    wr_addr_o = a;
    wr_data_o = d;
    @(negedge clk_i);
    wr_en_o = 1'b0;
    wr_addr_o = ~a;
    wr_data_o = ~d;
  endtask
  task automatic soft_reset;
    wr(CTRL_ONE_ADDR, SOFT_RESET_CMD);
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(negedge clk_i);
    rd_en_o = 1'b1;
    rd_addr_o = a;
    @(negedge clk_i);
    d = rd_data_i;
    rd_en_o = 1'b0;
    rd_addr_o = ~a;
  endtask
endmodule // rcs_host

//--- test/rcs_ctrl_test.sv
`timescale 1ns/100ps
`define CHK(n, e, a) begin n_checks++; if ((a) !== (e)) begin \
  $display("ERROR %s exp %h got %h", n, e, a); fails++; end end
module rcs_ctrl_test;
  import rcs_pkg::*;
  logic clk_i, arst_n_i, osc, corr, pin_drv, wr_en, rd_en;
  logic [7:0] wr_addr, wr_data, rd_addr, rd_data, rb;
  logic [2:0] sel;
  logic irq, h12, cap, halted, tick, srst, pin_o, pin_oe, err;
  int fails = 0;
  int n_checks = 0;
  int ticks = 0;
  int t0;
  // Pin level: the block drives it outside test mode, the bench inside
  wire logic pin = pin_oe ? pin_o : pin_drv;
  rcs_host host (.clk_i(clk_i), .rd_data_i(rd_data), .wr_en_o(wr_en), .wr_addr_o(wr_addr),
    .wr_data_o(wr_data), .rd_en_o(rd_en), .rd_addr_o(rd_addr));
  rcs_ctrl uut (.clk_i(clk_i), .arst_n_i(arst_n_i), .osc_tick_i(osc), .wr_en_i(wr_en),
    .wr_addr_i(wr_addr), .wr_data_i(wr_data), .rd_en_i(rd_en), .rd_addr_i(rd_addr),
    .rd_data_o(rd_data), .corr_cycle_i(corr), .corr_irq_o(irq), .hour_12_o(h12),
    .load_cap_o(cap), .halted_o(halted), .sec_tick_o(tick), .soft_reset_o(srst),
    .clock_output_pin_i(pin), .clock_output_pin_o(pin_o), .clock_output_pin_oe_o(pin_oe),
    .clock_output_pin_sel_i(sel), .test_clk_err_o(err));
  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end
  // Oscillator runs free in every mode, so test mode must ignore it
  initial begin
    osc = 1'b0;
    forever @(negedge clk_i) osc = ~osc;
  end
  // Count ticks mid-cycle, where the registered pulse has settled
  always @(negedge clk_i) if (tick === 1'b1) ticks++;
  task automatic corr_pulse(input logic e);
    @(negedge clk_i) corr = 1'b1;
    @(negedge clk_i) corr = 1'b0;
    `CHK("corr_irq", e, irq)
  endtask
  // Test clock at the shortest legal pulse, well inside the period limit
  task automatic pulses(input int n);
    repeat (n) begin
      @(negedge clk_i) pin_drv = 1'b1;
      repeat (TEST_MIN_PULSE_CYC) @(negedge clk_i);
      pin_drv = 1'b0;
      repeat (TEST_MIN_PULSE_CYC - 1) @(negedge clk_i);
    end
  endtask
  task automatic t_fields;
    host.rd(8'h00, rb);
    `CHK("reset value", CTRL_ONE_RESET, rb)
    host.wr(8'h00, 8'h6f);
    host.rd(8'h00, rb);
    `CHK("read back", 8'h27, rb)
    `CHK("hour_12", 1'b1, h12)
    `CHK("load_cap", 1'b1, cap)
    corr_pulse(1'b1);
    host.wr(8'h00, 8'h00);
    `CHK("hour_24", 1'b0, h12)
    corr_pulse(1'b0);
    host.rd(8'h05, rb);
    `CHK("unmapped", 8'h00, rb)
  endtask
  task automatic t_soft_reset;
    host.wr(8'h00, 8'ha7);
    host.soft_reset();
    `CHK("soft_reset", 1'b1, srst)
    host.rd(8'h00, rb);
    `CHK("after reset", 8'h00, rb)
  endtask
  task automatic t_test_mode;
    host.wr(8'h00, 8'h80);
    `CHK("pin input", 1'b0, pin_oe)
    host.wr(8'h00, 8'ha0);
    host.wr(8'h00, 8'h80);
    // Low phase before the first pulse must also meet the minimum width
    repeat (TEST_MIN_PULSE_CYC) @(negedge clk_i);
    t0 = ticks;
    pulses(31);
    `CHK("no tick at 31", 0, ticks - t0)
    pulses(1);
    `CHK("tick at 32", 1, ticks - t0)
    pulses(63);
    `CHK("no tick at 95", 1, ticks - t0)
    pulses(1);
    `CHK("tick at 96", 2, ticks - t0)
    `CHK("test clk ok", 1'b0, err)
    host.wr(8'h00, 8'ha0);
    pulses(64);
    `CHK("halted test", 2, ticks - t0)
    host.wr(8'h00, 8'h00);
  endtask
  task automatic t_halt_normal;
    sel = 3'h6;
    host.wr(8'h00, 8'h20);
    t0 = ticks;
    repeat (300) @(negedge clk_i);
    `CHK("clock_output_pin quiet", 1'b0, pin_o)
    `CHK("frozen", 0, ticks - t0)
    host.wr(8'h00, 8'h00);
    t0 = ticks;
    repeat (33240) @(negedge clk_i);
    `CHK("early tick", 0, ticks - t0)
    repeat (80) @(negedge clk_i);
    `CHK("first tick", 1, ticks - t0)
  endtask
  task automatic print_verdict;
    $display("fails=%0d n_checks=%0d", fails, n_checks);
    if (fails == 0 && n_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  initial begin
    repeat (90000) @(posedge clk_i);
    fails++;
    print_verdict();
  end
  initial begin
    arst_n_i = 1'b0;
    corr = 1'b0;
    pin_drv = 1'b0;
    sel = 3'h0;
    repeat (3) @(negedge clk_i);
    arst_n_i = 1'b1;
    t_fields();
    t_soft_reset();
    t_test_mode();
    t_halt_normal();
    print_verdict();
  end
endmodule // rcs_ctrl_test
